//--- hw/eeprom_pkg.sv
package eeprom_pkg;

  // ****************************************************************
  // Bus framing
  // ****************************************************************
  localparam logic [3:0] DEV_CODE      = 4'hA;  // Fixed upper nibble
  localparam logic [3:0] BYTE_BITS     = 4'h8;  // Bits per byte
  localparam int         ADDR_W        = 9;     // Word address width
  localparam int         MEM_WORDS     = 512;   // Array depth
  localparam int         PAGE_LOW_W    = 4;     // Page offset width
  localparam int         DATA_W        = 8;     // Word width

  // ****************************************************************
  // Write buffer geometry
  // ****************************************************************
  localparam int         FIFO_DEPTH    = 16;               // Entries
  localparam int         FIFO_WIDTH    = ADDR_W + DATA_W;  // Addr+data

  // ****************************************************************
  // Program cycle timing
  // ****************************************************************
  localparam int         CLK_PERIOD_NS = 5;        // System clock
  localparam int         WRITE_TIME_NS = 5000000;  // Longest write time
  // Longest time rounds down to whole cycles
  localparam int         PROG_CYCLES   = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int         PROG_CNT_W    = 20;       // Counter width

  // ****************************************************************
  // Frame states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE,       // Standby, waiting for a start
    ST_DEV_ADDR,   // Shifting in the device address byte
    ST_DEV_ACK,    // Acknowledging the device address
    ST_WORD_ADDR,  // Shifting in the word address byte
    ST_WORD_ACK,   // Acknowledging the word address
    ST_WR_DATA,    // Shifting in a write data byte
    ST_WR_ACK,     // Acknowledging a write data byte
    ST_RD_DATA,    // Shifting out a read data byte
    ST_RD_ACK      // Sampling the master acknowledge
  } frame_state_t;

endpackage

//--- hw/serial_eeprom_two_wire_slave.sv
`timescale 1ns/1ps

// ******************************************************************
// Write buffer: parameterised FIFO with valid/ready on both sides
// ******************************************************************
module write_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int PW = $clog2(DEPTH);

  // Pointers carry one extra bit to tell full from empty
  typedef struct packed {
    logic [PW:0] wr_ptr;  // Next slot to fill
    logic [PW:0] rd_ptr;  // Next slot to drain
  } fifo_state_t;

  fifo_state_t      s;                 // Registered state
  fifo_state_t      next_s;            // Next state
  logic [WIDTH-1:0] store [DEPTH];     // Entry storage
  logic             do_push;           // Accepted write
  logic             do_pop;            // Accepted read

  // Honest flags straight from the pointers
  assign in_ready  = (s.wr_ptr[PW] == s.rd_ptr[PW]) ||
                     (s.wr_ptr[PW-1:0] != s.rd_ptr[PW-1:0]);
  assign out_valid = (s.wr_ptr != s.rd_ptr);
  assign out_data  = store[s.rd_ptr[PW-1:0]];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  // Pointer advance
  always_comb begin
    next_s = s;
    if (do_push) begin
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (do_pop) begin
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Entry storage needs no reset
  always_ff @(posedge clk) begin
    if (do_push) begin
      store[s.wr_ptr[PW-1:0]] <= in_data;
    end
  end

endmodule

// ******************************************************************
// Two-wire serial memory slave
// ******************************************************************
// Operation
// - Sample on clock rise, change on fall
// - Data pin only pulled low or released
// - Two straps select device; floating reads low
// - Protect pin high blocks all programming
// - Data change with clock high is framing
// - Falling data, clock high: start, restarts frame
// - Rising data, clock high: stop, to standby
// - Bytes of eight, ack low on ninth
// - Address byte must begin one-zero-one-zero
// - Strap bits match; next bit is address MSB
// - Last address bit: one read, zero write
// - Match acks low; mismatch idles until start
// - Byte write: address, word, data, stop
// - Busy programming: ignore bus, never ack
// - Page write: up to sixteen acked bytes
// - Writes increment only low four address bits
// - Address counter keeps last access plus one
// - Reads increment full address, wrap to zero
// - Current read shifts out byte at counter
// - Master ack continues reading; nack ends
module serial_eeprom_two_wire_slave #(
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic bus_select_lower_strap,
  input  wire logic bus_select_upper_strap,
  input  wire logic unused_select_input,
  input  wire logic write_protect,
  output logic      program_busy
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                                scl_s1;     // Clock sync 1
    logic                                scl_s2;     // Clock sync 2
    logic                                scl_d;      // Clock delayed
    logic                                sda_s1;     // Data sync 1
    logic                                sda_s2;     // Data sync 2
    logic                                sda_d;      // Data delayed
    logic                                wp_s1;      // Protect sync 1
    logic                                wp_s2;      // Protect sync 2
    logic                                up_s1;      // Upper strap 1
    logic                                up_s2;      // Upper strap 2
    logic                                lo_s1;      // Lower strap 1
    logic                                lo_s2;      // Lower strap 2
    eeprom_pkg::frame_state_t            st;         // Frame state
    logic [3:0]                          bitcnt;     // Bits this byte
    logic [eeprom_pkg::DATA_W-1:0]       shreg;      // Receive shifter
    logic [eeprom_pkg::DATA_W-1:0]       tx;         // Transmit shifter
    logic [eeprom_pkg::ADDR_W-1:0]       addr;       // Word counter
    logic                                page_sel;   // Address MSB
    logic                                rw;         // Direction bit
    logic                                mack;       // Master ack seen
    logic                                wr_pending; // Data buffered
    logic                                flush;      // Discarding data
    logic                                busy;       // Program cycle
    logic [eeprom_pkg::PROG_CNT_W-1:0]   prog_cnt;   // Busy timer
    logic                                pull_low;   // Drive pin low
    logic                                out_level;  // Driven level
  } slave_state_t;

  slave_state_t                          s;          // Registered state
  slave_state_t                          next_s;     // Next state
  logic [eeprom_pkg::DATA_W-1:0]         mem [eeprom_pkg::MEM_WORDS];
  logic                                  scl_rise;   // Clock rose
  logic                                  scl_fall;   // Clock fell
  logic                                  start_seen; // Start condition
  logic                                  stop_seen;  // Stop condition
  logic                                  push_valid; // Data to buffer
  logic                                  push_ready; // Buffer has room
  logic [eeprom_pkg::FIFO_WIDTH-1:0]     push_data;  // Address and data
  logic [eeprom_pkg::FIFO_WIDTH-1:0]     pop_data;   // Entry to program
  logic                                  pop_valid;  // Entry pending
  logic                                  pop_ready;  // Draining now

  // Next address within the page: only the low bits roll over
  function automatic logic [eeprom_pkg::ADDR_W-1:0] page_inc(
    input logic [eeprom_pkg::ADDR_W-1:0] a
  );
    logic [eeprom_pkg::PAGE_LOW_W-1:0] low;
    low = a[eeprom_pkg::PAGE_LOW_W-1:0] + 1'b1;
    return {a[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_LOW_W], low};
  endfunction

  // ****************************************************************
  // Pin event decode, on the synchronised copies only
  // ****************************************************************
  assign scl_rise   = s.scl_s2 && !s.scl_d;
  assign scl_fall   = !s.scl_s2 && s.scl_d;
  // Data moving with clock high frames the transfer
  assign start_seen = s.scl_s2 && s.scl_d && s.sda_d && !s.sda_s2;
  assign stop_seen  = s.scl_s2 && s.scl_d && !s.sda_d && s.sda_s2;

  // Buffer drains while programming or while discarding
  assign pop_ready  = s.busy || s.flush;
  assign push_data  = {s.addr, s.shreg};

  // Buffer between the serial front end and the array
  write_fifo #(
    .WIDTH (eeprom_pkg::FIFO_WIDTH),
    .DEPTH (eeprom_pkg::FIFO_DEPTH)
  ) u_write_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_data   (push_data),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (pop_data),
    .out_valid (pop_valid),
    .out_ready (pop_ready)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_s     = s;
    push_valid = 1'b0;

    // Two-flop synchronisers on every pin the logic reads
    next_s.scl_s1 = scl_in;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_d  = s.scl_s2;
    next_s.sda_s1 = sda_in;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_d  = s.sda_s2;
    next_s.wp_s1  = write_protect;
    next_s.wp_s2  = s.wp_s1;
    next_s.up_s1  = bus_select_upper_strap;
    next_s.up_s2  = s.up_s1;
    next_s.lo_s1  = bus_select_lower_strap;
    next_s.lo_s2  = s.lo_s1;
    next_s.out_level = 1'b0;

    // Program cycle timer
    if (s.busy) begin
      if (int'(s.prog_cnt) == PROG_CYCLES - 1) begin
        next_s.busy     = 1'b0;
        next_s.prog_cnt = '0;
      end else begin
        next_s.prog_cnt = s.prog_cnt + 1'b1;
      end
    end

    // Discard ends once the buffer is empty
    if (s.flush && !pop_valid) begin
      next_s.flush = 1'b0;
    end

    if (s.busy) begin
      // Programming: the bus is ignored entirely
      next_s.st       = eeprom_pkg::ST_IDLE;
      next_s.pull_low = 1'b0;
    end else if (start_seen) begin
      // Start restarts frame decoding
      next_s.st       = eeprom_pkg::ST_DEV_ADDR;
      next_s.bitcnt   = '0;
      next_s.pull_low = 1'b0;
      if (s.wr_pending) begin
        // Write cut short by a restart is never programmed
        next_s.flush      = 1'b1;
        next_s.wr_pending = 1'b0;
      end
    end else if (stop_seen) begin
      // Stop returns to standby
      next_s.st       = eeprom_pkg::ST_IDLE;
      next_s.pull_low = 1'b0;
      if (s.wr_pending) begin
        next_s.wr_pending = 1'b0;
        if (s.wp_s2) begin
          next_s.flush    = 1'b1;
        end else begin
          next_s.busy     = 1'b1;
          next_s.prog_cnt = '0;
        end
      end
    end else if (scl_rise) begin
      // Sample incoming data on the rising clock
      case (s.st)
        eeprom_pkg::ST_DEV_ADDR,
        eeprom_pkg::ST_WORD_ADDR,
        eeprom_pkg::ST_WR_DATA: begin
          next_s.shreg  = {s.shreg[eeprom_pkg::DATA_W-2:0], s.sda_s2};
          next_s.bitcnt = s.bitcnt + 1'b1;
        end
        eeprom_pkg::ST_RD_DATA: begin
          next_s.bitcnt = s.bitcnt + 1'b1;
        end
        eeprom_pkg::ST_RD_ACK: begin
          next_s.mack = !s.sda_s2;
        end
        default: begin
          next_s.bitcnt = s.bitcnt;
        end
      endcase
    end else if (scl_fall) begin
      // Outgoing level changes on the falling clock
      case (s.st)
        eeprom_pkg::ST_DEV_ADDR: begin
          if (s.bitcnt == eeprom_pkg::BYTE_BITS) begin
            if (s.shreg[7:4] == eeprom_pkg::DEV_CODE &&
                s.shreg[3] == s.up_s2 &&
                s.shreg[2] == s.lo_s2) begin
              next_s.page_sel = s.shreg[1];
              next_s.rw       = s.shreg[0];
              next_s.pull_low = 1'b1;
              next_s.st       = eeprom_pkg::ST_DEV_ACK;
            end else begin
              next_s.st       = eeprom_pkg::ST_IDLE;
            end
          end
        end
        eeprom_pkg::ST_DEV_ACK: begin
          next_s.bitcnt = '0;
          if (s.rw) begin
            // Current address read from the counter
            next_s.tx       = mem[s.addr];
            next_s.pull_low = !mem[s.addr][eeprom_pkg::DATA_W-1];
            next_s.st       = eeprom_pkg::ST_RD_DATA;
          end else begin
            next_s.pull_low = 1'b0;
            next_s.st       = eeprom_pkg::ST_WORD_ADDR;
          end
        end
        eeprom_pkg::ST_WORD_ADDR: begin
          if (s.bitcnt == eeprom_pkg::BYTE_BITS) begin
            // Word address loads counter; dummy write ends here
            next_s.addr     = {s.page_sel, s.shreg};
            next_s.pull_low = 1'b1;
            next_s.st       = eeprom_pkg::ST_WORD_ACK;
          end
        end
        eeprom_pkg::ST_WORD_ACK: begin
          next_s.pull_low = 1'b0;
          next_s.bitcnt   = '0;
          next_s.st       = eeprom_pkg::ST_WR_DATA;
        end
        eeprom_pkg::ST_WR_DATA: begin
          if (s.bitcnt == eeprom_pkg::BYTE_BITS) begin
            if (push_ready) begin
              // Buffer byte and ack; page wraps in place
              push_valid        = 1'b1;
              next_s.addr       = page_inc(s.addr);
              next_s.wr_pending = 1'b1;
              next_s.pull_low   = 1'b1;
              next_s.st         = eeprom_pkg::ST_WR_ACK;
            end else begin
              // No room: byte refused without an ack
              next_s.st         = eeprom_pkg::ST_IDLE;
            end
          end
        end
        eeprom_pkg::ST_WR_ACK: begin
          next_s.pull_low = 1'b0;
          next_s.bitcnt   = '0;
          next_s.st       = eeprom_pkg::ST_WR_DATA;
        end
        eeprom_pkg::ST_RD_DATA: begin
          if (s.bitcnt == eeprom_pkg::BYTE_BITS) begin
            // Byte done: release for master ack, step counter
            next_s.pull_low = 1'b0;
            next_s.addr     = s.addr + 1'b1;
            next_s.st       = eeprom_pkg::ST_RD_ACK;
          end else begin
            next_s.tx       = {s.tx[eeprom_pkg::DATA_W-2:0], 1'b0};
            next_s.pull_low = !s.tx[eeprom_pkg::DATA_W-2];
          end
        end
        eeprom_pkg::ST_RD_ACK: begin
          next_s.bitcnt = '0;
          if (s.mack) begin
            // Master ack: next sequential byte
            next_s.tx       = mem[s.addr];
            next_s.pull_low = !mem[s.addr][eeprom_pkg::DATA_W-1];
            next_s.st       = eeprom_pkg::ST_RD_DATA;
          end else begin
            // No ack: stay released until stop
            next_s.pull_low = 1'b0;
            next_s.st       = eeprom_pkg::ST_IDLE;
          end
        end
        default: begin
          next_s.pull_low = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      s    <= '0;
      s.st <= eeprom_pkg::ST_IDLE;
    end else begin
      s    <= next_s;
    end
  end

  // Array programming from the buffer during the busy interval
  always_ff @(posedge clk) begin
    if (pop_valid && s.busy) begin
      mem[pop_data[eeprom_pkg::FIFO_WIDTH-1:eeprom_pkg::DATA_W]] <=
        pop_data[eeprom_pkg::DATA_W-1:0];
    end
  end

  // ****************************************************************
  // Outputs, all from flops
  // ****************************************************************
  assign sda_oe       = s.pull_low;
  assign sda_out      = s.out_level;
  assign program_busy = s.busy;

endmodule

//--- dv/eeprom_checker.sv
`timescale 1ns/1ps
// ************
// Port checker
// ************
module eeprom_checker #(
  parameter int PROG_CYCLES = 200
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire logic program_busy
);
  // Helper state: length of the running busy interval
  typedef struct packed {
    logic [31:0] run;  // Busy cycles so far
  } chk_state_t;
  chk_state_t st;       // Registered state
  chk_state_t next_st;  // Its next value
  // Count while busy, clear otherwise
  always_comb begin
    next_st     = st;
    next_st.run = program_busy ? st.run + 32'h1 : 32'h0;
  end
  // Register the helper state
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_open_drain;
    sda_oe |-> !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data pin driven high");
  property p_oe_low_clock;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_oe_low_clock: assert property (p_oe_low_clock)
    else $error("data output moved while clock high");
  property p_oe_holds;
    $rose(sda_oe) |=> sda_oe [*8];
  endproperty
  a_oe_holds: assert property (p_oe_holds)
    else $error("driven bit shorter than a clock period");
  property p_busy_quiet;
    program_busy |-> !sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("line driven while programming");
  property p_busy_after_stop;
    $rose(program_busy) |-> scl_in && sda_in;
  endproperty
  a_busy_after_stop: assert property (p_busy_after_stop)
    else $error("program cycle began without a stop");
  property p_protect_no_busy;
    $rose(program_busy) |-> !write_protect;
  endproperty
  a_protect_no_busy: assert property (p_protect_no_busy)
    else $error("program cycle while protected");
  property p_busy_length;
    $fell(program_busy) |-> st.run == PROG_CYCLES;
  endproperty
  a_busy_length: assert property (p_busy_length)
    else $error("program cycle length wrong");
  property p_reset_quiet;
    disable iff (1'b0) srst |=> !sda_oe && !program_busy;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
endmodule

bind serial_eeprom_two_wire_slave eeprom_checker #(
  .PROG_CYCLES(PROG_CYCLES)
) chk_u (
  .clk, .srst, .scl_in, .sda_in, .sda_out, .sda_oe, .write_protect,
  .program_busy
);

//--- dv/bus_master_model.sv
`timescale 1ns/1ps
// *******************
// Two-wire bus master
// *******************
module bus_master_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull_low
);
  // Idle bus: clock high, data left to the pull-up
  initial begin
    scl          = 1'b1;
    sda_pull_low = 1'b0;
  end
  // Steps taken at falling system clock edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One bit of 65 ns: data moves mid-low, sampled mid-high
  task automatic bit_slot(input logic b, output logic seen);
    tick(3);
    sda_pull_low = ~b;
    tick(4);
    scl = 1'b1;
    tick(3);
    seen = sda_line;
    tick(3);
    scl = 1'b0;
  endtask
  // Start, or repeated start from a low clock
  task automatic start();
    if (!scl) begin
      tick(3);
      sda_pull_low = 1'b0;
      tick(3);
      scl = 1'b1;
    end
    tick(6);
    sda_pull_low = 1'b1;
    tick(6);
    scl = 1'b0;
  endtask
  // Stop: data rises with the clock high, then the bus rests
  task automatic stop();
    tick(3);
    sda_pull_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(6);
    sda_pull_low = 1'b0;
    tick(6);
  endtask
  // Byte out, top bit first, then the answer slot released
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
    bit_slot(1'b1, s);
    acked = ~s;
  endtask
  // Byte in; ack asks for more, no-ack ends the read
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      b[i] = s;
    end
    bit_slot(~ack, s);
  endtask
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
// *********************
// Two-wire memory bench
// *********************
`define check_eq(what, want, got) \
  begin \
    checks_done++; \
    if ((got) !== (want)) begin \
      failures++; \
      $display("ERROR %s expected %0h seen %0h", what, want, got); \
    end \
  end
module testbench;
  localparam int PROG = 200;  // Short program cycle
  // Address byte cases: straps, byte sent, acknowledge expected
  typedef struct packed {
    logic       upper;
    logic       lower;
    logic [7:0] addr;
    logic       ack;
  } row_t;
  localparam row_t rows [0:6] = '{'{1'b0, 1'b1, 8'hA4, 1'b1},
    '{1'b0, 1'b1, 8'hA0, 1'b0}, '{1'b0, 1'b1, 8'hAC, 1'b0},
    '{1'b1, 1'b0, 8'hA8, 1'b1}, '{1'b1, 1'b1, 8'hBC, 1'b0},
    '{1'b1, 1'b1, 8'hAD, 1'b1}, '{1'b0, 1'b0, 8'hE0, 1'b0}};
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       bus_select_upper_strap = 1'b0;
  logic       bus_select_lower_strap = 1'b1;
  logic       unused_select_input = 1'b1;  // Must be ignored
  logic       write_protect = 1'b0;
  logic       scl_in;                      // Bus clock
  logic       sda_in;                      // Resolved data line
  logic       sda_pull_low;                // Master pulls data low
  logic       sda_out;
  logic       sda_oe;
  logic       program_busy;
  logic       ok;                          // Last acknowledge seen
  logic [7:0] rd;                          // Unchecked read byte
  int         failures = 0;
  int         checks_done = 0;
  // 200 MHz system clock
  always #2.5 clk = ~clk;
  // Open-drain line with pull-up
  assign sda_in = ~(sda_pull_low | (sda_oe & ~sda_out));
  bus_master_model master_u (
    .clk, .scl(scl_in), .sda_line(sda_in), .sda_pull_low
  );
  serial_eeprom_two_wire_slave #(.PROG_CYCLES(PROG)) dut_u (
    .clk, .srst, .scl_in, .sda_in, .sda_out, .sda_oe, .write_protect,
    .bus_select_lower_strap, .bus_select_upper_strap,
    .unused_select_input, .program_busy
  );
  // Address byte for straps upper 0, lower 1
  function automatic logic [7:0] dev_byte(input logic rw, input logic pg);
    return {eeprom_pkg::DEV_CODE, 2'h1, pg, rw};
  endfunction
  // Bounded wait for the program cycle to end
  task automatic wait_idle();
    for (int n = 0; n < 4 * PROG && program_busy !== 1'b0; n++) begin
      @(negedge clk);
    end
    `check_eq("busy clears", 1'b0, program_busy)
  endtask
  // Write n bytes counting up from first
  task automatic write_seq(input logic [8:0] a, input int n,
                           input logic [7:0] first);
    master_u.start();
    master_u.send_byte(dev_byte(1'b0, a[8]), ok);
    `check_eq("write address ack", 1'b1, ok)
    master_u.send_byte(a[7:0], ok);
    `check_eq("word address ack", 1'b1, ok)
    for (int i = 0; i < n; i++) begin
      master_u.send_byte(first + 8'(i), ok);
      `check_eq("data ack", 1'b1, ok)
    end
    master_u.stop();
  endtask
  // Optional dummy write, then a read of the wanted bytes
  task automatic read_seq(input logic dummy, input logic [8:0] a,
                          input logic [7:0] want [$]);
    logic [7:0] b;
    if (dummy) begin
      master_u.start();
      master_u.send_byte(dev_byte(1'b0, a[8]), ok);
      master_u.send_byte(a[7:0], ok);
      `check_eq("dummy write ack", 1'b1, ok)
    end
    master_u.start();
    master_u.send_byte(dev_byte(1'b1, 1'b0), ok);
    `check_eq("read address ack", 1'b1, ok)
    foreach (want[i]) begin
      master_u.recv_byte(i < want.size() - 1, b);
      `check_eq("read data", want[i], b)
    end
    master_u.stop();
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    master_u.tick(6);
    foreach (rows[i]) begin
      bus_select_upper_strap = rows[i].upper;
      bus_select_lower_strap = rows[i].lower;
      master_u.tick(4);
      master_u.start();
      master_u.send_byte(rows[i].addr, ok);
      `check_eq("address ack", rows[i].ack, ok)
      if (ok && rows[i].addr[0]) master_u.recv_byte(1'b0, rd);
      master_u.stop();
      wait_idle();
    end
    bus_select_upper_strap = 1'b0;
    bus_select_lower_strap = 1'b1;
    master_u.tick(4);
    write_seq(9'h10C, 16, 8'h30);
    `check_eq("busy after stop", 1'b1, program_busy)
    master_u.start();
    master_u.send_byte(dev_byte(1'b0, 1'b0), ok);
    `check_eq("poll while busy", 1'b0, ok)
    master_u.stop();
    wait_idle();
    master_u.start();
    master_u.send_byte(dev_byte(1'b0, 1'b0), ok);
    `check_eq("poll when done", 1'b1, ok)
    master_u.stop();
    wait_idle();
    write_seq(9'h1FF, 1, 8'h5A);
    wait_idle();
    write_seq(9'h000, 1, 8'hC3);
    wait_idle();
    read_seq(1'b1, 9'h100, '{8'h34, 8'h35, 8'h36, 8'h37});
    read_seq(1'b0, 9'h000, '{8'h38});
    read_seq(1'b1, 9'h1FF, '{8'h5A, 8'hC3});
    write_protect = 1'b1;
    master_u.tick(4);
    write_seq(9'h000, 1, 8'h11);
    `check_eq("protected busy", 1'b0, program_busy)
    write_protect = 1'b0;
    read_seq(1'b1, 9'h000, '{8'hC3});
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    `check_eq("oe after reset", 1'b0, sda_oe)
    `check_eq("busy after reset", 1'b0, program_busy)
    master_u.tick(6);
    read_seq(1'b0, 9'h000, '{8'hC3});
    stop_test();
  end
  // Watchdog against a hung bus
  initial begin
    #200000;
    failures++;
    stop_test();
  end
endmodule
